/* File: design/pefs_defines.svh */
// Purpose: constants for the port E upper pin function select block
// Assumes: apb byte addressing, 32-bit data
// Notes: offsets, reset values and field positions only, no logic
`ifndef PEFS_DEFINES_SVH
`define PEFS_DEFINES_SVH

// -----------------------------------------------------------------------------
// register map
// -----------------------------------------------------------------------------
`define PEFS_CTRL_OFFSET 12'h000
`define PEFS_STATUS_OFFSET 12'h004
`define PEFS_CTRL_RESET 16'h0000

// -----------------------------------------------------------------------------
// field positions
// -----------------------------------------------------------------------------
`define PEFS_PIN15_LSB 14
`define PEFS_PIN14_LSB 12
`define PEFS_PIN13_LSB 10
`define PEFS_PIN12_LSB 8

`endif

/* File: design/pefs_pkg.sv */
// Purpose: shared types for the pin function select block
// Assumes: nothing beyond standard systemverilog
// Notes: types only, constants sit in the defines header
package pefs_pkg;

  // function of one pin after decode
  typedef enum logic [2:0] {
    PEFS_FN_PORT,
    PEFS_FN_TIMER,
    PEFS_FN_ALT_OUT,
    PEFS_FN_ALT_IN,
    PEFS_FN_SERIAL,
    PEFS_FN_DEBUG_CLK
  } pefs_fn_t;

  // apb request carrier
  typedef struct packed {
    logic sel;
    logic enable;
    logic write;
    logic [11:0] addr;
    logic [31:0] wdata;
  } pefs_apb_req_t;

endpackage

/* File: design/pefs_pin_decode.sv */
// Purpose: decode one two-bit field into a pin function
// Assumes: table of four function codes given per pin
// Notes: prohibited codes are mapped to port i/o by the caller's table
`timescale 1ns/1ps

module pefs_pin_decode #(
  parameter logic [11:0] FN_TABLE = 12'h000
) (
  input wire logic [1:0] field,
  output pefs_pkg::pefs_fn_t fn
);

  // pick the 3-bit entry for this code
  always_comb begin
    fn = pefs_pkg::pefs_fn_t'(FN_TABLE[field*3 +: 3]);
  end

endmodule

/* File: design/pefs_top.sv */
// Purpose: pin function multiplexer for port E pins 15 to 12
// Assumes: apb slave, single clock pclk, async active-low reset
// Notes: peripheral signals are plain ports, pads use in/out/oe triples
//
// The register addresses and the APB interface to the registers were decided locally.
`timescale 1ns/1ps
`include "pefs_defines.svh"

// How it works
// (RQ1) pin 15: 00 port, 01 timer 4D, 10 dma ack 1, 11 interrupt request out.
// (RQ2) pin 14: 00 port, 01 timer 4C, 10 dma ack 0, 11 prohibited.
// (RQ3) pin 13: 00 port, 01 timer 4B, 10 manual reset in, 11 prohibited.
// (RQ4) pin 12: 00 port, 01 timer 4A, 10 prohibited.
// (RQ5) pin 12 code 11 drives serial 3 transmit data.
// (RQ6) debug mode input high forces pin 12 to debug test clock input.
// (RQ7) fields are read/write and reset to zero, so pins start as port.
// (RQ8) software never writes prohibited codes; here they act as port i/o.
module pefs_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic debug_mode_input,
  input wire logic [3:0] port_out,
  input wire logic [3:0] port_oe,
  output logic [3:0] port_in,
  input wire logic [3:0] timer_out,
  input wire logic [3:0] timer_oe,
  output logic [3:0] timer_in,
  input wire logic dma_ack_one_out,
  input wire logic dma_ack_zero_out,
  input wire logic interrupt_request_out,
  output logic manual_reset_in,
  input wire logic serial3_transmit_out,
  output logic debug_test_clock_in,
  input wire logic [3:0] pad_in,
  output logic [3:0] pad_out,
  output logic [3:0] pad_oe
);

  // -----------------------------------------------------------------------------
  // apb register access
  // -----------------------------------------------------------------------------
  pefs_pkg::pefs_apb_req_t req;
  logic [15:0] ctrl_ff;
  logic [31:0] nxt_prdata;
  logic hit_ctrl;
  logic hit_status;
  pefs_pkg::pefs_fn_t fn [4];

  assign req = '{sel: psel, enable: penable, write: pwrite, addr: paddr, wdata: pwdata};
  assign hit_ctrl = (req.addr == `PEFS_CTRL_OFFSET);
  assign hit_status = (req.addr == `PEFS_STATUS_OFFSET);
  assign pready = 1'b1; // zero wait states
  assign pslverr = req.sel & req.enable & ~(hit_ctrl | (hit_status & ~req.write));

  // control register, all fields clear at reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff <= `PEFS_CTRL_RESET; // RQ7
    end else if (req.sel && req.enable && req.write && hit_ctrl) begin
      ctrl_ff <= {req.wdata[15:8], 8'h00}; // RQ7
    end
  end

  // read data mux
  always_comb begin
    nxt_prdata = 32'h0000_0000;
    if (hit_ctrl) begin
      nxt_prdata = {16'h0000, ctrl_ff};
    end else if (hit_status) begin
      nxt_prdata = {19'h0_0000, debug_mode_input, 3'(fn[3]), 3'(fn[2]), 3'(fn[1]), 3'(fn[0])};
    end
  end

  // read data registered in setup phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (req.sel && !req.enable && !req.write) begin
      prdata <= nxt_prdata;
    end
  end

  // -----------------------------------------------------------------------------
  // field decode, prohibited codes fall back to port
  // -----------------------------------------------------------------------------
  // entries {code11,code10,code01,code00}, 3 bits each
  pefs_pin_decode #(.FN_TABLE({3'(pefs_pkg::PEFS_FN_ALT_OUT), 3'(pefs_pkg::PEFS_FN_ALT_OUT),
                               3'(pefs_pkg::PEFS_FN_TIMER), 3'(pefs_pkg::PEFS_FN_PORT)}))
    u_dec15 (.field(ctrl_ff[`PEFS_PIN15_LSB +: 2]), .fn(fn[3])); // RQ1
  pefs_pin_decode #(.FN_TABLE({3'(pefs_pkg::PEFS_FN_PORT), 3'(pefs_pkg::PEFS_FN_ALT_OUT),
                               3'(pefs_pkg::PEFS_FN_TIMER), 3'(pefs_pkg::PEFS_FN_PORT)}))
    u_dec14 (.field(ctrl_ff[`PEFS_PIN14_LSB +: 2]), .fn(fn[2])); // RQ2 RQ8
  pefs_pin_decode #(.FN_TABLE({3'(pefs_pkg::PEFS_FN_PORT), 3'(pefs_pkg::PEFS_FN_ALT_IN),
                               3'(pefs_pkg::PEFS_FN_TIMER), 3'(pefs_pkg::PEFS_FN_PORT)}))
    u_dec13 (.field(ctrl_ff[`PEFS_PIN13_LSB +: 2]), .fn(fn[1])); // RQ3 RQ8
  pefs_pkg::pefs_fn_t fn12_raw;
  pefs_pin_decode #(.FN_TABLE({3'(pefs_pkg::PEFS_FN_SERIAL), 3'(pefs_pkg::PEFS_FN_PORT),
                               3'(pefs_pkg::PEFS_FN_TIMER), 3'(pefs_pkg::PEFS_FN_PORT)}))
    u_dec12 (.field(ctrl_ff[`PEFS_PIN12_LSB +: 2]), .fn(fn12_raw)); // RQ4 RQ5 RQ8
  // debug mode overrides the pin 12 field
  assign fn[0] = debug_mode_input ? pefs_pkg::PEFS_FN_DEBUG_CLK : fn12_raw; // RQ6

  // -----------------------------------------------------------------------------
  // pad multiplexing
  // -----------------------------------------------------------------------------
  // alternate output source per pin
  logic [3:0] alt_out;
  assign alt_out = {ctrl_ff[15:14] == 2'h3 ? interrupt_request_out : dma_ack_one_out, // RQ1
                    dma_ack_zero_out, 1'b0, serial3_transmit_out}; // RQ2 RQ5

  // drive pads from the selected function
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      unique case (fn[i])
        pefs_pkg::PEFS_FN_PORT: begin
          pad_out[i] = port_out[i];
          pad_oe[i] = port_oe[i];
        end
        pefs_pkg::PEFS_FN_TIMER: begin
          pad_out[i] = timer_out[i];
          pad_oe[i] = timer_oe[i];
        end
        pefs_pkg::PEFS_FN_ALT_OUT, pefs_pkg::PEFS_FN_SERIAL: begin
          pad_out[i] = alt_out[i];
          pad_oe[i] = 1'b1;
        end
        default: begin // inputs only
          pad_out[i] = 1'b0;
          pad_oe[i] = 1'b0;
        end
      endcase
      port_in[i] = (fn[i] == pefs_pkg::PEFS_FN_PORT) ? pad_in[i] : 1'b0;
      timer_in[i] = (fn[i] == pefs_pkg::PEFS_FN_TIMER) ? pad_in[i] : 1'b0;
    end
  end

  // manual reset input idles high and debug test clock input idles low when not selected
  assign manual_reset_in = (fn[1] == pefs_pkg::PEFS_FN_ALT_IN) ? pad_in[1] : 1'b1; // RQ3
  assign debug_test_clock_in = debug_mode_input ? pad_in[0] : 1'b0; // RQ6

  // -----------------------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // bus phases seen by the register checks
  sequence apb_setup_s;
    psel && !penable;
  endsequence

  sequence ctrl_write_s;
    psel && penable && pwrite && hit_ctrl;
  endsequence

  sequence ctrl_read_s;
    apb_setup_s ##0 (!pwrite && hit_ctrl);
  endsequence

  sequence status_read_s;
    apb_setup_s ##0 (!pwrite && hit_status);
  endsequence

  // pin 15 routing per code
  pin15_irq_a: assert property (ctrl_ff[15:14] == 2'h3 |-> pad_oe[3] && pad_out[3] == interrupt_request_out) // RQ1
    else $error("pin 15 not driving interrupt request");
  pin15_dack_a: assert property (ctrl_ff[15:14] == 2'h2 |-> pad_oe[3] && pad_out[3] == dma_ack_one_out) // RQ1
    else $error("pin 15 not driving dma ack 1");
  pin15_timer_a: assert property (ctrl_ff[15:14] == 2'h1 |-> // RQ1
    pad_oe[3] == timer_oe[3] && pad_out[3] == timer_out[3] && timer_in[3] == pad_in[3])
    else $error("pin 15 timer not routed");
  pin15_port_a: assert property (ctrl_ff[15:14] == 2'h0 |-> // RQ7
    pad_oe[3] == port_oe[3] && pad_out[3] == port_out[3] && port_in[3] == pad_in[3])
    else $error("pin 15 port not routed");

  // pin 14 routing per code
  pin14_dack_a: assert property (ctrl_ff[13:12] == 2'h2 |-> pad_oe[2] && pad_out[2] == dma_ack_zero_out) // RQ2
    else $error("pin 14 not driving dma ack 0");
  pin14_timer_a: assert property (ctrl_ff[13:12] == 2'h1 |-> // RQ2
    pad_oe[2] == timer_oe[2] && pad_out[2] == timer_out[2] && timer_in[2] == pad_in[2])
    else $error("pin 14 timer not routed");
  pin14_port_a: assert property (ctrl_ff[13:12] == 2'h0 |-> // RQ7
    pad_oe[2] == port_oe[2] && pad_out[2] == port_out[2] && port_in[2] == pad_in[2])
    else $error("pin 14 port not routed");
  prohib_port_a: assert property (ctrl_ff[13:12] == 2'h3 |-> pad_oe[2] == port_oe[2]) // RQ8
    else $error("prohibited code not treated as port");

  // pin 13 routing per code
  pin13_manual_reset_in_a: assert property (ctrl_ff[11:10] == 2'h2 |-> !pad_oe[1] && manual_reset_in == pad_in[1]) // RQ3
    else $error("pin 13 manual reset not routed");
  pin13_timer_a: assert property (ctrl_ff[11:10] == 2'h1 |-> // RQ3
    pad_oe[1] == timer_oe[1] && pad_out[1] == timer_out[1] && timer_in[1] == pad_in[1])
    else $error("pin 13 timer not routed");
  pin13_prohib_a: assert property (ctrl_ff[11:10] == 2'h3 |-> // RQ3 RQ8
    pad_oe[1] == port_oe[1] && port_in[1] == pad_in[1])
    else $error("pin 13 prohibited code not treated as port");
  manual_reset_in_idle_a: assert property (ctrl_ff[11:10] != 2'h2 |-> manual_reset_in) // RQ3
    else $error("manual reset not idle high");

  // pin 12 routing per code and debug override
  pin12_timer_a: assert property (!debug_mode_input && ctrl_ff[9:8] == 2'h1 |-> pad_oe[0] == timer_oe[0]) // RQ4
    else $error("pin 12 timer not routed");
  pin12_prohib_a: assert property (!debug_mode_input && ctrl_ff[9:8] == 2'h2 |-> // RQ4 RQ8
    pad_oe[0] == port_oe[0] && port_in[0] == pad_in[0])
    else $error("pin 12 prohibited code not treated as port");
  pin12_serial_a: assert property (!debug_mode_input && ctrl_ff[9:8] == 2'h3 |-> // RQ5
    pad_oe[0] && pad_out[0] == serial3_transmit_out)
    else $error("pin 12 serial not routed");
  debug_force_a: assert property (debug_mode_input |-> !pad_oe[0] && debug_test_clock_in == pad_in[0]) // RQ6
    else $error("debug clock not forced on pin 12");
  debug_idle_a: assert property (!debug_mode_input |-> !debug_test_clock_in) // RQ6
    else $error("debug clock active outside debug mode");

  // register store, hold and read back
  ctrl_write_a: assert property (ctrl_write_s |=> ctrl_ff == ($past(pwdata[15:0]) & 16'hFF00)) // RQ7
    else $error("control write not stored");
  ctrl_hold_a: assert property (!(psel && penable && pwrite && hit_ctrl) |=> $stable(ctrl_ff)) // RQ7
    else $error("control changed without a write");
  ctrl_read_a: assert property (ctrl_read_s |=> prdata == {16'h0000, $past(ctrl_ff)}) // RQ7
    else $error("control read data wrong");
  ctrl_ok_a: assert property (psel && penable && hit_ctrl |-> !pslverr) // RQ7
    else $error("control access flagged as error");
  status_read_a: assert property (status_read_s |=> prdata[12] == $past(debug_mode_input)) // RQ6
    else $error("status debug bit wrong");

endmodule

/* File: verif/pefs_top_tb_top.sv */
// Purpose: self-checking bench for the port E upper pin function select block
// Assumes: apb slave with zero wait states, ctrl and status offsets from the defines header
// Notes: every field code is swept with and without debug mode, pins are checked against a local table
`timescale 1ns/1ps
`include "pefs_defines.svh"

module pefs_top_tb_top;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, debug_mode_input = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd, st_exp;
  logic pready, pslverr, err, manual_reset_in, debug_test_clock_in;
  logic [3:0] port_out = 4'h5, port_oe = 4'h3, timer_out = 4'hA, timer_oe = 4'hC, pad_in = 4'h5;
  logic dma_ack_one_out = 1'b0, dma_ack_zero_out = 1'b1, interrupt_request_out = 1'b1, serial3_transmit_out = 1'b0;
  logic [3:0] port_in, timer_in, pad_out, pad_oe;
  logic [4:0] ex;
  int miscompares = 0, total_checks = 0, cycles = 0;

  pefs_top i_pefs_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .debug_mode_input(debug_mode_input), .port_out(port_out), .port_oe(port_oe), .port_in(port_in),
    .timer_out(timer_out), .timer_oe(timer_oe), .timer_in(timer_in), .dma_ack_one_out(dma_ack_one_out),
    .dma_ack_zero_out(dma_ack_zero_out), .interrupt_request_out(interrupt_request_out),
    .manual_reset_in(manual_reset_in), .serial3_transmit_out(serial3_transmit_out),
    .debug_test_clock_in(debug_test_clock_in), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe));

  // ---------------------------------------------------------------------------
  // clock, timeout and verdict
  // ---------------------------------------------------------------------------
  initial begin
    forever #4 pclk = ~pclk;
  end

  // hang guard, the sweep needs well under a thousand cycles
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      miscompares = miscompares + 1;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    if (miscompares == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // ---------------------------------------------------------------------------
  // apb master and compare
  // ---------------------------------------------------------------------------
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    total_checks = total_checks + 1;
    if (got !== exp) begin
      miscompares = miscompares + 1;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask

  // expected {function, drive enable, drive level} of pin i for field code c
  function automatic logic [4:0] pin_exp(input int i, input logic [1:0] c, input logic d);
    logic [2:0] fn;
    logic oe, o;
    fn = pefs_pkg::PEFS_FN_PORT; oe = port_oe[i]; o = port_out[i];
    if (c == 2'h1) begin fn = pefs_pkg::PEFS_FN_TIMER; oe = timer_oe[i]; o = timer_out[i]; end
    else if (c == 2'h2 && i >= 2) begin
      fn = pefs_pkg::PEFS_FN_ALT_OUT; oe = 1'b1; o = (i == 3) ? dma_ack_one_out : dma_ack_zero_out;
    end
    else if (c == 2'h2 && i == 1) begin fn = pefs_pkg::PEFS_FN_ALT_IN; oe = 1'b0; end
    else if (c == 2'h3 && i == 3) begin fn = pefs_pkg::PEFS_FN_ALT_OUT; oe = 1'b1; o = interrupt_request_out; end
    else if (c == 2'h3 && i == 0) begin fn = pefs_pkg::PEFS_FN_SERIAL; oe = 1'b1; o = serial3_transmit_out; end
    if (i == 0 && d) begin fn = pefs_pkg::PEFS_FN_DEBUG_CLK; oe = 1'b0; end
    return {fn, oe, o};
  endfunction

  // ---------------------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------------------
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `PEFS_CTRL_OFFSET, 32'h0); chk("ctrl reset", 32'h0, rd);
    apb(1'b1, `PEFS_CTRL_OFFSET, 32'hFFFF_FFFF); chk("ctrl err", 32'h0, 32'(err));
    apb(1'b0, `PEFS_CTRL_OFFSET, 32'h0);
    chk("ctrl width", 32'h0000_FF00, rd);
    apb(1'b1, 12'h0FC, 32'h0); chk("unmapped err", 32'h1, 32'(err));
    apb(1'b0, 12'h0FC, 32'h0); chk("unmapped data", 32'h0, rd);
    apb(1'b1, `PEFS_STATUS_OFFSET, 32'h0); chk("status write err", 32'h1, 32'(err));
    apb(1'b0, `PEFS_CTRL_OFFSET, 32'h0); chk("ctrl kept", 32'h0000_FF00, rd);
    // sweep all codes in all four fields, with debug mode off then on
    for (int d = 0; d < 2; d++) begin
      debug_mode_input <= d[0];
      for (int c = 0; c < 4; c++) begin
        apb(1'b1, `PEFS_CTRL_OFFSET, {16'h0, {4{c[1:0]}}, 8'h00});
        apb(1'b0, `PEFS_CTRL_OFFSET, 32'h0); chk("ctrl", {16'h0, {4{c[1:0]}}, 8'h00}, rd);
        apb(1'b0, `PEFS_STATUS_OFFSET, 32'h0);
        #1;
        st_exp = {19'h0, d[0], 12'h000};
        for (int i = 0; i < 4; i++) begin
          ex = pin_exp(i, c[1:0], d[0]);
          st_exp[3*i +: 3] = ex[4:2];
          chk("pad_oe", 32'(ex[1]), 32'(pad_oe[i]));
          chk("pad_out", 32'(ex[1] & ex[0]), 32'(ex[1] & pad_out[i]));
          chk("port_in", 32'(ex[4:2] == 3'(pefs_pkg::PEFS_FN_PORT) ? pad_in[i] : 1'b0), 32'(port_in[i]));
          chk("timer_in", 32'(ex[4:2] == 3'(pefs_pkg::PEFS_FN_TIMER) ? pad_in[i] : 1'b0), 32'(timer_in[i]));
        end
        chk("status", st_exp, rd);
        chk("manual_reset_in", 32'(c == 2 ? pad_in[1] : 1'b1), 32'(manual_reset_in));
        chk("debug_clk", 32'(d[0] & pad_in[0]), 32'(debug_test_clock_in));
      end
    end
    // second reset in mid-run returns every pin to port i/o
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    debug_mode_input <= 1'b0;
    apb(1'b0, `PEFS_CTRL_OFFSET, 32'h0); chk("ctrl rereset", 32'h0, rd);
    #1;
    chk("pad_oe rereset", 32'(port_oe), 32'(pad_oe));
    report_and_stop();
  end
endmodule
